// *** design/ctm_hold.sv ***
`timescale 1ns/100ps
module ctm_hold (
   input wire logic clk_i,
   input wire logic reset_n_i,
   ctm_hold_if.store hb
);
   logic [31:0] acc_reg;
   logic [63:0] cap_reg;
   // ==========================================
   // Holding stores
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         acc_reg <= 32'h00000000;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (hb.latch && hb.en[i]) begin
               acc_reg[i*8 +: 8] <= hb.acc_in[i*8 +: 8];
            end else if (hb.wr && hb.wr_sel == 2'(i)) begin
               acc_reg[i*8 +: 8] <= hb.wr_data;
            end
         end
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         cap_reg <= 64'h0000000000000000;
      end else if (hb.latch) begin
         cap_reg <= hb.cap_in;
      end
   end

   assign hb.acc_hold = acc_reg;
   assign hb.cap_hold = cap_reg;

   a_cap_latch: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      hb.latch |=> hb.cap_hold == $past(hb.cap_in))
      else $error("capture hold not latched");
endmodule : ctm_hold

// *** design/ctm_hold_if.sv ***
`timescale 1ns/100ps
interface ctm_hold_if;
   logic latch;
   logic [3:0] en;
   logic [31:0] acc_in;
   logic [63:0] cap_in;
   logic wr;
   logic [1:0] wr_sel;
   logic [7:0] wr_data;
   logic [31:0] acc_hold;
   logic [63:0] cap_hold;
   modport owner (output latch, en, acc_in, cap_in, wr, wr_sel, wr_data,
      input acc_hold, cap_hold);
   modport store (input latch, en, acc_in, cap_in, wr, wr_sel, wr_data,
      output acc_hold, cap_hold);
endinterface : ctm_hold_if

// *** design/ctm_pkg.sv ***
package ctm_pkg;
   // ==========================================
   // Register indices (byte address = index)
   localparam logic [4:0] ADDR_TIMER_CTL = 5'h00;
   localparam logic [4:0] ADDR_MOD_CTL = 5'h01;
   localparam logic [4:0] ADDR_CAP_SYS = 5'h02;
   localparam logic [4:0] ADDR_ACCCTL = 5'h03;
   localparam logic [4:0] ADDR_PBCTL = 5'h04;
   localparam logic [4:0] ADDR_B_FLAG = 5'h05;
   localparam logic [4:0] ADDR_MOD_FLAG = 5'h06;
   localparam logic [4:0] ADDR_ACC_HI = 5'h07;
   localparam logic [4:0] ADDR_ACC_LO = 5'h08;
   localparam logic [4:0] ADDR_ACC3H = 5'h09;
   localparam logic [4:0] ADDR_ACC2H = 5'h0A;
   localparam logic [4:0] ADDR_ACC1H = 5'h0B;
   localparam logic [4:0] ADDR_ACC0H = 5'h0C;
   localparam logic [4:0] ADDR_MOD_CNT = 5'h0D;
   localparam logic [4:0] ADDR_CAP0_HOLD = 5'h0E;
   localparam logic [4:0] ADDR_TCNT = 5'h12;
   localparam logic [4:0] ADDR_ACC32 = 5'h13;
   // ==========================================
   // Field positions
   localparam int TCTL_ENABLE = 7;
   localparam int TCTL_SWAI = 6;
   localparam int TCTL_DBGF = 5;
   localparam int TCTL_FFC = 4;
   localparam int MC_MODE = 6;
   localparam int MC_RDLD = 5;
   localparam int MC_FORCE = 3;
   localparam int MC_EN = 2;
   localparam int IC_BUF = 1;
   localparam int IC_LATCH = 0;
   localparam int PB_EN = 6;
   localparam int PA_EN = 7;
   localparam int PBF_OVF = 1;
   localparam int MCF_ZF = 7;
   // ==========================================
   // Reset values and timing
   localparam logic [7:0] CTRL_RST = 8'h00;
   localparam logic [15:0] WORD_RST = 16'h0000;
   localparam logic [3:0] PRESCALE_DIV = 4'h3;
endpackage : ctm_pkg

// *** design/ctm_timer.sv ***
`timescale 1ns/100ps
// Operation
// - Overflow flag sets on cascaded 16-bit or accumulator one 8-bit wrap.
// - Writing one to flag bit 1 clears overflow; zero leaves it.
// - With fast clear, any access of either count byte clears the flag.
// - Enabled accumulator holds capture on latch; software reads and writes.
// - Count read returns live counter or load value per read-select bit.
// - Zero write with buffering and latch mode latches holding registers.
// - After zero write counter stays zero and zero flag not set.
// - Modulus mode write goes to load register, taken at underflow.
// - Force-load copies load register into counter immediately.
// - Non-modulus write clears prescaler, loads counter, counts once to zero.
// - Capture holding registers take channels 0-3 on latch; writes ignored.
// - Stop mode halts timer and modulus counter.
// - Debug mode keeps counting unless debug-freeze bit 5 set.
// - Wait mode keeps counting unless stop-in-wait bit set.
// - Timer runs with its enable, modulus counter with its own enable.
// - Timer enable clear stops 16-bit timer; registers stay accessible.
// - Accumulator A enable: 16-bit A active, else 3 and 2 individually.
// - Accumulator B enable clear: accumulators 1 and 0 enabled individually.
// - Latch mode latch on modulus zero; copy holds, then clear accumulators.
// - Accumulator B enable cascades 1 (high) and 0 (low) into 16 bits.
module ctm_timer (
   input wire logic clk_i,
   input wire logic reset_n_i,
   input wire logic [4:0] addr_i,
   input wire logic [15:0] wdata_i,
   input wire logic wr_i,
   input wire logic rd_i,
   output logic [15:0] rdata_o,
   input wire logic stop_mode_i,
   input wire logic wait_mode_i,
   input wire logic background_debug_mode_i,
   input wire logic [3:0] accum_edge_i,
   input wire logic [63:0] capture_i,
   output logic accum_b_overflow_flag_o,
   output logic modulus_zero_flag_o
);
   // ==========================================
   // Pin synchronisers
   logic [3:0] edge_s1_reg, edge_s2_reg, edge_s3_reg;
   logic [2:0] mode_s1_reg, mode_s2_reg;
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         edge_s1_reg <= 4'h0;
         edge_s2_reg <= 4'h0;
         edge_s3_reg <= 4'h0;
         mode_s1_reg <= 3'h0;
         mode_s2_reg <= 3'h0;
      end else begin
         edge_s1_reg <= accum_edge_i;
         edge_s2_reg <= edge_s1_reg;
         edge_s3_reg <= edge_s2_reg;
         mode_s1_reg <= {stop_mode_i, wait_mode_i, background_debug_mode_i};
         mode_s2_reg <= mode_s1_reg;
      end
   end
   logic [3:0] pulse;
   assign pulse = edge_s2_reg & ~edge_s3_reg;

   // ==========================================
   // Control registers
   logic [7:0] tctl_reg, mctl_reg, csys_reg, accctl_reg, pbctl_reg;
   logic wr_word, wr_acc_b;
   assign wr_word = wr_i;
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         tctl_reg <= ctm_pkg::CTRL_RST;
         mctl_reg <= ctm_pkg::CTRL_RST;
         csys_reg <= ctm_pkg::CTRL_RST;
         accctl_reg <= ctm_pkg::CTRL_RST;
         pbctl_reg <= ctm_pkg::CTRL_RST;
      end else if (wr_word) begin
         case (addr_i)
            ctm_pkg::ADDR_TIMER_CTL: tctl_reg <= wdata_i[7:0];
            ctm_pkg::ADDR_MOD_CTL: begin
               mctl_reg <= wdata_i[7:0];
               mctl_reg[ctm_pkg::MC_FORCE] <= 1'b0;
            end
            ctm_pkg::ADDR_CAP_SYS: csys_reg <= wdata_i[7:0];
            ctm_pkg::ADDR_ACCCTL: accctl_reg <= wdata_i[7:0];
            ctm_pkg::ADDR_PBCTL: pbctl_reg <= wdata_i[7:0];
            default: ;
         endcase
      end
   end

   logic dbg_s, wait_s, stop_s, clk_run;
   assign stop_s = mode_s2_reg[2];
   assign wait_s = mode_s2_reg[1];
   assign dbg_s = mode_s2_reg[0];
   // Halt conditions shared by the main timer and the modulus counter
   assign clk_run = !stop_s
      && !(dbg_s && tctl_reg[ctm_pkg::TCTL_DBGF])
      && !(wait_s && tctl_reg[ctm_pkg::TCTL_SWAI]);
   logic timer_enable_bit, modulus_enable_bit, mod_mode, buf_latch, pa_en, pb_en;
   assign timer_enable_bit = tctl_reg[ctm_pkg::TCTL_ENABLE];
   assign modulus_enable_bit = mctl_reg[ctm_pkg::MC_EN];
   assign mod_mode = mctl_reg[ctm_pkg::MC_MODE];
   assign buf_latch = csys_reg[ctm_pkg::IC_BUF]
      && csys_reg[ctm_pkg::IC_LATCH];
   assign pa_en = pbctl_reg[ctm_pkg::PA_EN];
   assign pb_en = pbctl_reg[ctm_pkg::PB_EN];

   // ==========================================
   // Prescaler and main timer
   logic [3:0] pre_reg;
   logic tick;
   logic mc_write;
   assign mc_write = wr_word && addr_i == ctm_pkg::ADDR_MOD_CNT;
   assign tick = pre_reg == ctm_pkg::PRESCALE_DIV;
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         pre_reg <= 4'h0;
      end else if (mc_write && !mod_mode) begin
         pre_reg <= 4'h0;
      end else if (clk_run && (timer_enable_bit || modulus_enable_bit)) begin
         pre_reg <= tick ? 4'h0 : pre_reg + 4'h1;
      end
   end

   logic [15:0] tcnt_reg;
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         tcnt_reg <= ctm_pkg::WORD_RST;
      end else if (clk_run && timer_enable_bit && tick) begin
         tcnt_reg <= tcnt_reg + 16'h0001;
      end
   end

   // ==========================================
   // Modulus down-counter
   logic [15:0] mc_cnt_reg, mc_load_reg;
   logic mc_zf_reg, mc_hold_reg, underflow, latch_ev;
   assign underflow = clk_run && modulus_enable_bit && tick && mc_cnt_reg == 16'h0001
      && !mc_hold_reg;
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         mc_load_reg <= ctm_pkg::WORD_RST;
      end else if (mc_write) begin
         mc_load_reg <= wdata_i;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         mc_cnt_reg <= ctm_pkg::WORD_RST;
         mc_hold_reg <= 1'b0;
      end else if (wr_word && addr_i == ctm_pkg::ADDR_MOD_CTL
            && wdata_i[ctm_pkg::MC_FORCE]) begin
         mc_cnt_reg <= mc_load_reg;
         mc_hold_reg <= mc_load_reg == 16'h0000;
      end else if (mc_write && (wdata_i == 16'h0000)) begin
         mc_cnt_reg <= 16'h0000;
         mc_hold_reg <= 1'b1;
      end else if (mc_write && !mod_mode) begin
         mc_cnt_reg <= wdata_i;
         mc_hold_reg <= 1'b0;
      end else if (clk_run && modulus_enable_bit && tick && mc_cnt_reg != 16'h0000) begin
         if (mc_cnt_reg == 16'h0001 && mod_mode) begin
            mc_cnt_reg <= mc_load_reg;
         end else begin
            mc_cnt_reg <= mc_cnt_reg - 16'h0001;
         end
      end
   end

   logic mflag_clr;
   assign mflag_clr = wr_word && addr_i == ctm_pkg::ADDR_MOD_FLAG
      && wdata_i[ctm_pkg::MCF_ZF];
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         mc_zf_reg <= 1'b0;
      end else if (underflow) begin
         mc_zf_reg <= 1'b1;
      end else if (mflag_clr) begin
         mc_zf_reg <= 1'b0;
      end
   end
   assign modulus_zero_flag_o = mc_zf_reg;

   assign latch_ev = buf_latch && (underflow
      || (mc_write && wdata_i == 16'h0000));

   // ==========================================
   // Pulse accumulators
   logic [7:0] acc_reg [4];
   logic [3:0] acc_en;
   assign acc_en[3] = !pa_en && accctl_reg[3];
   assign acc_en[2] = !pa_en && accctl_reg[2];
   assign acc_en[1] = !pb_en && accctl_reg[1];
   assign acc_en[0] = !pb_en && accctl_reg[0];

   logic acc_b_access, b_wrap;
   assign acc_b_access = (rd_i || wr_i)
      && (addr_i == ctm_pkg::ADDR_ACC_HI || addr_i == ctm_pkg::ADDR_ACC_LO);
   assign wr_acc_b = wr_i && addr_i == ctm_pkg::ADDR_ACC_HI;
   // Cascade wrap in B mode, or accumulator one wrap alone
   assign b_wrap = pb_en ? (pulse[0] && {acc_reg[1], acc_reg[0]} == 16'hFFFF)
      : (acc_en[1] && pulse[1] && acc_reg[1] == 8'hFF);

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         for (int i = 0; i < 4; i++) acc_reg[i] <= 8'h00;
      end else if (latch_ev) begin
         for (int i = 0; i < 4; i++) acc_reg[i] <= 8'h00;
      end else begin
         if (pb_en && pulse[0]) begin
            {acc_reg[1], acc_reg[0]} <=
               {acc_reg[1], acc_reg[0]} + 16'h0001;
         end
         if (pa_en && pulse[2]) begin
            {acc_reg[3], acc_reg[2]} <= {acc_reg[3], acc_reg[2]} + 16'h0001;
         end
         for (int i = 0; i < 4; i++) begin
            if (acc_en[i] && pulse[i]) acc_reg[i] <= acc_reg[i] + 8'h01;
         end
         if (wr_acc_b) begin
            acc_reg[1] <= wdata_i[15:8];
            acc_reg[0] <= wdata_i[7:0];
         end
      end
   end

   logic ovf_reg, ovf_clr;
   assign ovf_clr = (wr_i && addr_i == ctm_pkg::ADDR_B_FLAG
      && wdata_i[ctm_pkg::PBF_OVF])
      || (tctl_reg[ctm_pkg::TCTL_FFC] && acc_b_access);
   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         ovf_reg <= 1'b0;
      end else if (b_wrap) begin
         ovf_reg <= 1'b1;
      end else if (ovf_clr) begin
         ovf_reg <= 1'b0;
      end
   end
   assign accum_b_overflow_flag_o = ovf_reg;

   // ==========================================
   // Holding registers
   ctm_hold_if hbus ();
   assign hbus.latch = latch_ev;
   assign hbus.en = {4{buf_latch}} & accctl_reg[3:0];
   assign hbus.acc_in = {acc_reg[3], acc_reg[2], acc_reg[1], acc_reg[0]};
   assign hbus.cap_in = capture_i;
   assign hbus.wr = wr_i && addr_i >= ctm_pkg::ADDR_ACC3H
      && addr_i <= ctm_pkg::ADDR_ACC0H;
   assign hbus.wr_sel = 2'(ctm_pkg::ADDR_ACC0H - addr_i);
   assign hbus.wr_data = wdata_i[7:0];

   ctm_hold u_hold (
      .clk_i(clk_i),
      .reset_n_i(reset_n_i),
      .hb(hbus.store)
   );

   // ==========================================
   // Read port
   function automatic logic [15:0] ctm_byte(input logic [7:0] b);
      return {8'h00, b};
   endfunction : ctm_byte

   always_ff @(posedge clk_i) begin
      if (!reset_n_i) begin
         rdata_o <= 16'h0000;
      end else if (rd_i) begin
         case (addr_i)
            ctm_pkg::ADDR_TIMER_CTL: rdata_o <= ctm_byte(tctl_reg);
            ctm_pkg::ADDR_MOD_CTL: rdata_o <= ctm_byte(mctl_reg);
            ctm_pkg::ADDR_CAP_SYS: rdata_o <= ctm_byte(csys_reg);
            ctm_pkg::ADDR_ACCCTL: rdata_o <= ctm_byte(accctl_reg);
            ctm_pkg::ADDR_PBCTL: rdata_o <= ctm_byte(pbctl_reg);
            ctm_pkg::ADDR_B_FLAG: rdata_o <= ctm_byte({6'h00, ovf_reg, 1'b0});
            ctm_pkg::ADDR_MOD_FLAG: rdata_o <= ctm_byte({mc_zf_reg, 7'h00});
            ctm_pkg::ADDR_ACC_HI: rdata_o <= {acc_reg[1], acc_reg[0]};
            ctm_pkg::ADDR_ACC32: rdata_o <= {acc_reg[3], acc_reg[2]};
            ctm_pkg::ADDR_ACC3H: rdata_o <= ctm_byte(hbus.acc_hold[31:24]);
            ctm_pkg::ADDR_ACC2H: rdata_o <= ctm_byte(hbus.acc_hold[23:16]);
            ctm_pkg::ADDR_ACC1H: rdata_o <= ctm_byte(hbus.acc_hold[15:8]);
            ctm_pkg::ADDR_ACC0H: rdata_o <= ctm_byte(hbus.acc_hold[7:0]);
            ctm_pkg::ADDR_MOD_CNT: rdata_o <= mctl_reg[ctm_pkg::MC_RDLD]
               ? mc_load_reg : mc_cnt_reg;
            ctm_pkg::ADDR_CAP0_HOLD: rdata_o <= hbus.cap_hold[15:0];
            5'h0F: rdata_o <= hbus.cap_hold[31:16];
            5'h10: rdata_o <= hbus.cap_hold[47:32];
            5'h11: rdata_o <= hbus.cap_hold[63:48];
            ctm_pkg::ADDR_TCNT: rdata_o <= tcnt_reg;
            default: rdata_o <= 16'h0000;
         endcase
      end
   end

   // ==========================================
   // Checks
   a_ovf_clear: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (ovf_clr && !b_wrap) |=> !accum_b_overflow_flag_o)
      else $error("overflow flag not cleared");
   a_ovf_set: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      b_wrap |=> accum_b_overflow_flag_o)
      else $error("overflow flag not set");
   sequence s_zero_write;
      mc_write && wdata_i == 16'h0000 && !mflag_clr;
   endsequence
   sequence s_bus_quiet;
      !wr_i [*2];
   endsequence
   a_zero_stays: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      s_zero_write ##1 s_bus_quiet
      |-> mc_cnt_reg == 16'h0000 && !underflow)
      else $error("counter left zero");
   a_stop_halt: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (stop_s && !mc_write) |=> $stable(tcnt_reg))
      else $error("timer ran in stop");
   a_ten_halt: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      !timer_enable_bit |=> $stable(tcnt_reg))
      else $error("timer ran while disabled");
   a_latch_clear: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      latch_ev |=> acc_reg[1] == 8'h00 && acc_reg[3] == 8'h00)
      else $error("accumulators not cleared");
   a_mod_write: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (mc_write && mod_mode && wdata_i != 16'h0000 && !underflow)
      |=> mc_load_reg == $past(wdata_i))
      else $error("load register not written");
   a_direct_load: assert property (@(posedge clk_i) disable iff (!reset_n_i)
      (mc_write && !mod_mode) |=> mc_cnt_reg == $past(wdata_i))
      else $error("counter not loaded");
endmodule : ctm_timer

// *** dv/tb_capture_timer_modulus_holding.sv ***
`timescale 1ns/100ps
module tb_capture_timer_modulus_holding;
   // ==========================================
   // Signals and bench state
   logic clk_i = 1'b0;
   logic reset_n_i;
   logic [4:0] addr_i;
   logic [15:0] wdata_i;
   logic wr_i;
   logic rd_i;
   logic [15:0] rdata_o;
   logic stop_mode_i;
   logic wait_mode_i;
   logic background_debug_mode_i;
   logic [3:0] accum_edge_i;
   logic [63:0] capture_i;
   logic accum_b_overflow_flag_o;
   logic modulus_zero_flag_o;
   int mismatches = 0;
   int comparisons = 0;
   int seed;
   int acc_m[4];
   logic [15:0] v;
   logic [7:0] hb[4];
   logic [4:0] rl[9];
   logic [4:0] tbl[6];

   always #50 clk_i = ~clk_i;

   ctm_timer DUT (
      .clk_i(clk_i), .reset_n_i(reset_n_i), .addr_i(addr_i),
      .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
      .stop_mode_i(stop_mode_i), .wait_mode_i(wait_mode_i),
      .background_debug_mode_i(background_debug_mode_i),
      .accum_edge_i(accum_edge_i), .capture_i(capture_i),
      .accum_b_overflow_flag_o(accum_b_overflow_flag_o),
      .modulus_zero_flag_o(modulus_zero_flag_o)
   );

   // ==========================================
   // Tasks; each one is entered and left just after a rising edge
   task automatic report_and_stop();
      $display("Comparisons %0d, mismatches %0d", comparisons, mismatches);
      if (mismatches == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : report_and_stop

   task automatic chk(string n, logic [15:0] e, logic [15:0] g);
      comparisons++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", n, e, g);
      end
   endtask : chk

   task automatic cyc(int n);
      repeat (n) @(posedge clk_i);
   endtask : cyc

   // Extra idle edge keeps a following strobe out of this time step
   task automatic wr(logic [4:0] a, logic [15:0] d);
      addr_i <= a;
      wdata_i <= d;
      wr_i <= 1'b1;
      @(posedge clk_i);
      wr_i <= 1'b0;
      @(posedge clk_i);
   endtask : wr

   task automatic rd(logic [4:0] a, output logic [15:0] d);
      addr_i <= a;
      rd_i <= 1'b1;
      @(posedge clk_i);
      rd_i <= 1'b0;
      #1;
      d = rdata_o;
      @(posedge clk_i);
   endtask : rd

   task automatic rd_chk(string n, logic [4:0] a, logic [15:0] e);
      logic [15:0] d;
      rd(a, d);
      chk(n, e, d);
   endtask : rd_chk

   task automatic bflag(logic e);
      #1;
      chk("b_overflow_flag", {15'h0000, e},
         {15'h0000, accum_b_overflow_flag_o});
      @(posedge clk_i);
   endtask : bflag

   task automatic zflag(logic e);
      #1;
      chk("modulus_zero_flag", {15'h0000, e},
         {15'h0000, modulus_zero_flag_o});
      @(posedge clk_i);
   endtask : zflag

   // Input is synchronised, so each level is held for four clocks
   task automatic pulse(int k);
      accum_edge_i[k] <= 1'b1;
      cyc(4);
      accum_edge_i[k] <= 1'b0;
      cyc(4);
      acc_m[k] = (acc_m[k] + 1) % 256;
   endtask : pulse

   task automatic wait_zf();
      int i;
      i = 0;
      @(posedge clk_i);
      #1;
      while (modulus_zero_flag_o !== 1'b1 && i < 1000) begin
         @(posedge clk_i);
         #1;
         i++;
      end
      comparisons++;
      if (i >= 1000) begin
         mismatches++;
         $display("[FAIL] zero flag wait expected 1 seen %b",
            modulus_zero_flag_o);
         report_and_stop();
      end
      @(posedge clk_i);
   endtask : wait_zf

   // A counter counts if two reads 42 clocks apart differ
   task automatic run_chk(logic [4:0] a, logic e);
      logic [15:0] x;
      logic [15:0] y;
      cyc(6);
      rd(a, x);
      cyc(40);
      rd(a, y);
      chk("counter running", {15'h0000, e}, {15'h0000, x !== y});
   endtask : run_chk

   // ==========================================
   // Main sequence
   initial begin
      seed = 32'h2657;
      reset_n_i = 1'b0;
      addr_i = 5'h00;
      wdata_i = 16'h0000;
      wr_i = 1'b0;
      rd_i = 1'b0;
      stop_mode_i = 1'b0;
      wait_mode_i = 1'b0;
      background_debug_mode_i = 1'b0;
      accum_edge_i = 4'h0;
      capture_i = 64'h0000000000000000;
      acc_m = '{0, 0, 0, 0};
      cyc(12);
      reset_n_i <= 1'b1;
      cyc(1);
      rl = '{ctm_pkg::ADDR_TIMER_CTL, ctm_pkg::ADDR_MOD_CTL,
         ctm_pkg::ADDR_CAP_SYS, ctm_pkg::ADDR_B_FLAG, ctm_pkg::ADDR_MOD_FLAG,
         ctm_pkg::ADDR_MOD_CNT, ctm_pkg::ADDR_CAP0_HOLD, ctm_pkg::ADDR_TCNT,
         5'h1F};
      for (int i = 0; i < 9; i++) begin
         rd_chk("reset value", rl[i], 16'h0000);
      end
      for (int j = 0; j < 4; j++) begin
         hb[j] = 8'($random(seed));
         wr(ctm_pkg::ADDR_ACC3H + 5'(j), {8'h00, hb[j]});
         rd_chk("accum hold rw", ctm_pkg::ADDR_ACC3H + 5'(j),
            {8'h00, hb[j]});
      end
      // Latch by zero write with buffering and latch mode
      // Channels 0-3 are treated as input captures throughout
      capture_i <= {32'($random(seed)), 32'($random(seed))};
      wr(ctm_pkg::ADDR_CAP_SYS, 16'h0003);
      wr(ctm_pkg::ADDR_ACCCTL, 16'h000F);
      for (int k = 0; k < 4; k++) begin
         for (int n = 0; n <= k; n++) begin
            pulse(k);
         end
      end
      wr(ctm_pkg::ADDR_MOD_CNT, 16'h0000);
      for (int j = 0; j < 4; j++) begin
         rd_chk("accum hold", ctm_pkg::ADDR_ACC3H + 5'(j),
            16'(acc_m[3 - j]));
      end
      for (int i = 0; i < 4; i++) begin
         rd_chk("capture hold", ctm_pkg::ADDR_CAP0_HOLD + 5'(i),
            capture_i[16 * i +: 16]);
      end
      acc_m = '{0, 0, 0, 0};
      wr(ctm_pkg::ADDR_CAP0_HOLD, ~capture_i[15:0]);
      rd_chk("capture hold write", ctm_pkg::ADDR_CAP0_HOLD,
         capture_i[15:0]);
      wr(ctm_pkg::ADDR_MOD_CNT, 16'h0000);
      rd_chk("accum cleared", ctm_pkg::ADDR_ACC3H, 16'(acc_m[3]));
      wr(ctm_pkg::ADDR_CAP_SYS, 16'h0000);
      // Eight-bit accumulator one wraps
      wr(ctm_pkg::ADDR_ACCCTL, 16'h0002);
      repeat (255) pulse(1);
      bflag(1'b0);
      pulse(1);
      bflag(1'b1);
      wr(ctm_pkg::ADDR_B_FLAG, 16'h0000);
      bflag(1'b1);
      wr(ctm_pkg::ADDR_B_FLAG, 16'h0002);
      bflag(1'b0);
      // Cascaded accumulator wraps, then fast clear by read and by write
      wr(ctm_pkg::ADDR_PBCTL, 16'h0040);
      wr(ctm_pkg::ADDR_ACC_HI, 16'hFFFE);
      pulse(0);
      bflag(1'b0);
      pulse(0);
      bflag(1'b1);
      for (int i = 0; i < 2; i++) begin
         wr(ctm_pkg::ADDR_TIMER_CTL, 16'h0000);
         wr(ctm_pkg::ADDR_ACC_HI, 16'hFFFF);
         pulse(0);
         bflag(1'b1);
         wr(ctm_pkg::ADDR_TIMER_CTL, 16'h0010);
         if (i == 0) begin
            rd(ctm_pkg::ADDR_ACC_LO, v);
         end else begin
            wr(ctm_pkg::ADDR_ACC_HI, 16'h0010);
         end
         bflag(1'b0);
      end
      wr(ctm_pkg::ADDR_TIMER_CTL, 16'h0000);
      // Modulus load register, read select and force load
      wr(ctm_pkg::ADDR_MOD_CTL, 16'h0040);
      wr(ctm_pkg::ADDR_MOD_CNT, 16'h1234);
      rd_chk("count live", ctm_pkg::ADDR_MOD_CNT, 16'h0000);
      wr(ctm_pkg::ADDR_MOD_CTL, 16'h0060);
      rd_chk("count load", ctm_pkg::ADDR_MOD_CNT, 16'h1234);
      wr(ctm_pkg::ADDR_MOD_CTL, 16'h0048);
      wr(ctm_pkg::ADDR_MOD_CTL, 16'h0040);
      rd_chk("force load", ctm_pkg::ADDR_MOD_CNT, 16'h1234);
      // One-shot count down without modulus mode
      wr(ctm_pkg::ADDR_MOD_CTL, 16'h0000);
      wr(ctm_pkg::ADDR_MOD_CNT, 16'h0005);
      rd_chk("one shot load", ctm_pkg::ADDR_MOD_CNT, 16'h0005);
      wr(ctm_pkg::ADDR_MOD_CTL, 16'h0004);
      cyc(40);
      rd_chk("one shot end", ctm_pkg::ADDR_MOD_CNT, 16'h0000);
      cyc(40);
      rd_chk("one shot stays", ctm_pkg::ADDR_MOD_CNT, 16'h0000);
      wr(ctm_pkg::ADDR_MOD_FLAG, 16'h0080);
      wr(ctm_pkg::ADDR_MOD_CNT, 16'h0000);
      cyc(60);
      zflag(1'b0);
      rd_chk("zero write", ctm_pkg::ADDR_MOD_CNT, 16'h0000);
      // Modulus mode reloads and flags every underflow
      wr(ctm_pkg::ADDR_MOD_CTL, 16'h0044);
      wr(ctm_pkg::ADDR_MOD_CNT, 16'h0007);
      wr(ctm_pkg::ADDR_MOD_CTL, 16'h004C);
      wait_zf();
      wr(ctm_pkg::ADDR_MOD_FLAG, 16'h0080);
      zflag(1'b0);
      wait_zf();
      wr(ctm_pkg::ADDR_MOD_CNT, 16'h0100);
      cyc(40);
      rd(ctm_pkg::ADDR_MOD_CNT, v);
      chk("reload at underflow", 16'h0001, {15'h0000, v > 16'h0007});
      // Low power and debug modes: {stop, wait, debug, stop-in-wait, freeze}
      tbl = '{5'b00000, 5'b10000, 5'b01000, 5'b01010, 5'b00100, 5'b00101};
      for (int e = 0; e < 6; e++) begin
         stop_mode_i <= tbl[e][4];
         wait_mode_i <= tbl[e][3];
         background_debug_mode_i <= tbl[e][2];
         wr(ctm_pkg::ADDR_TIMER_CTL,
            {8'h00, 1'b1, tbl[e][1], tbl[e][0], 5'h00});
         run_chk(ctm_pkg::ADDR_TCNT, e % 2 == 0);
         run_chk(ctm_pkg::ADDR_MOD_CNT, e % 2 == 0);
      end
      stop_mode_i <= 1'b0;
      background_debug_mode_i <= 1'b0;
      wr(ctm_pkg::ADDR_TIMER_CTL, 16'h0000);
      run_chk(ctm_pkg::ADDR_TCNT, 1'b0);
      rd_chk("access while off", ctm_pkg::ADDR_ACC3H,
         16'(acc_m[3]));
      wr(ctm_pkg::ADDR_MOD_CTL, 16'h0040);
      run_chk(ctm_pkg::ADDR_MOD_CNT, 1'b0);
      report_and_stop();
   end
endmodule : tb_capture_timer_modulus_holding
